// >>> design/cbsmb_defs.svh
// Offsets, field positions, reset values and timing counts of the
// clock buffer bus target. Included by bare name; definitions only.
`ifndef CBSMB_DEFS_SVH
`define CBSMB_DEFS_SVH
`define CBSMB_OFS_CTRL     8'h00
`define CBSMB_OFS_OE_LO    8'h01
`define CBSMB_OFS_OE_HI    8'h02
`define CBSMB_OFS_RSV_A    8'h03
`define CBSMB_OFS_RSV_B    8'h04
`define CBSMB_OFS_BCNT     8'h07
`define CBSMB_BIT_FREQ     0
`define CBSMB_BIT_MODE_LO  1
`define CBSMB_BIT_MODE_HI  2
`define CBSMB_BIT_SWEN     3
`define CBSMB_BIT_CMD_BYTE 7
`define CBSMB_RST_MODE     2'h3
`define CBSMB_RST_SWEN     1'h0
`define CBSMB_RST_OE_LO    8'hFF
`define CBSMB_RST_OE_HI    4'hF
`define CBSMB_RST_BCNT     5'h08
`define CBSMB_MAX_COUNT    6'h20
`define CBSMB_CAP_DELAY    2'h3
`define CBSMB_DEV_ADDR     7'h6C
`endif

// >>> design/cbsmb_pkg.sv
// Types of the clock buffer bus target.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cbsmb_pkg;
  typedef enum logic [2:0] {
    CBSMB_IDLE = 3'h0,
    CBSMB_RX   = 3'h1,
    CBSMB_ACK  = 3'h3,
    CBSMB_TX   = 3'h2,
    CBSMB_RACK = 3'h6,
    CBSMB_SKIP = 3'h7
  } cbsmb_state_t;

  typedef struct packed {
    cbsmb_state_t st;
    logic [3:0]   bitcnt;
    logic [7:0]   shreg;
    logic [1:0]   wb;
    logic         rw;
    logic         blk;
    logic         cnt_sent;
    logic         hacked;
    logic         sda_oe;
    logic         scl_d;
    logic         sda_d;
    logic [7:0]   idx;
    logic         sw_en;
    logic [1:0]   mode;
    logic [11:0]  oe_bits;
    logic [4:0]   bcnt;
    logic         freq_cap;
    logic [1:0]   pll_cap;
    logic [1:0]   cap_cnt;
    logic         cap_done;
    logic [1:0]   pll_eff;
    logic [11:0]  out_en;
  } cbsmb_regs_t;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } cbsmb_sync_t;
endpackage
`default_nettype wire

// >>> design/cbsmb_sync.sv
// Two-flop synchroniser for the pins of the clock buffer target.
// Assumes the pins are asynchronous to i_mclk.
`default_nettype none
module cbsmb_sync
  import cbsmb_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Pins in, synchronised out
  input  wire logic [5:0] i_async,
  output var  logic [5:0] o_sync
);
  cbsmb_sync_t sync_reg;
  cbsmb_sync_t sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = i_async;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync_reg <= '1; // Pins idle high
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg.s2;
endmodule // cbsmb_sync
`default_nettype wire

// >>> design/cbsmb_target.sv
// SMBus target and control registers of a twelve-output clock buffer.
// Assumes SCL/SDA/strap pins are asynchronous; SDA is open drain.
// Behaviour
// - Byte accesses name the register in the command byte after address.
// - Command bit 7 set means byte access, clear means block access.
// - After repeated start and read address, device returns register data.
// - Block read command has bit 7 clear; device acks that index.
// - Block read returns a count 1 to 31 first, then data bytes.
// - Block write takes command bits 6:0 as starting register index.
// - Command zero starts a block write at register zero.
// - Device acks every byte received in a block write.
// - Register 0 bit 3 chooses strap or software PLL mode, reset 0.
// - Register 0 bits 2:1 are software PLL mode, each resetting to 1.
// - Register 0 bits 7:6 always return the captured strap PLL mode.
// - Registers 3 and 4 and register 0 bits 5:4 read zero.
// - PLL code 00 low bandwidth, 01 bypass, 11 high bandwidth.
// - In power down the bus pins float and registers keep values.
// - Byte count register sets block read length, reset eight.
`default_nettype none
`include "cbsmb_defs.svh"
module cbsmb_target
  import cbsmb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CBSMB_DEV_ADDR
)(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // SMBus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output var  logic        o_sda,
  output var  logic        o_sda_oe,
  // Straps and power down
  input  wire logic        i_output_frequency_strap,
  input  wire logic [1:0]  i_pll_bandwidth_strap,
  input  wire logic        i_power_down_n,
  // Clock path controls
  output var  logic [11:0] o_differential_clock_out_en,
  output var  logic [1:0]  o_pll_mode,
  output var  logic        o_output_frequency_sel
);
  cbsmb_regs_t r_reg;
  cbsmb_regs_t r_next;
  logic [5:0]  pins_s;
  logic        scl;
  logic        sda;
  logic        pdn;
  logic        frq;
  logic [1:0]  pll;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        load;
  logic [7:0]  txb;
  logic        ev_cmd;
  logic        ev_wr;
  logic        ev_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  cbsmb_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async ({i_power_down_n, i_pll_bandwidth_strap,
               i_output_frequency_strap, i_sda, i_scl}),
    .o_sync  (pins_s)
  );

  assign scl   = pins_s[0];
  assign sda   = pins_s[1];
  assign frq   = pins_s[2];
  assign pll   = pins_s[4:3];
  assign pdn   = pins_s[5];
  assign rise  = scl & ~r_reg.scl_d;
  assign fall  = ~scl & r_reg.scl_d;
  assign start = scl & r_reg.scl_d & r_reg.sda_d & ~sda;
  assign stop  = scl & r_reg.scl_d & ~r_reg.sda_d & sda;

  ////////////////////////////////////////////////////////////////////////
  // Register readback
  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input cbsmb_regs_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `CBSMB_OFS_CTRL: v = {s.pll_cap, 2'h0, s.sw_en, s.mode,
                            s.freq_cap};
      `CBSMB_OFS_OE_LO: v = s.oe_bits[7:0];
      `CBSMB_OFS_OE_HI: v = {4'h0, s.oe_bits[11:8]};
      `CBSMB_OFS_BCNT:  v = {3'h0, s.bcnt};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_next       = r_reg;
    load         = 1'b0;
    txb          = 8'h00;
    ev_cmd       = 1'b0;
    ev_wr        = 1'b0;
    ev_cnt       = 1'b0;
    r_next.scl_d = scl;
    r_next.sda_d = sda;
    if (!r_reg.cap_done) begin
      r_next.cap_cnt = r_reg.cap_cnt + 2'h1;
      if (r_reg.cap_cnt == `CBSMB_CAP_DELAY) begin
        r_next.freq_cap = frq;
        r_next.pll_cap  = pll;
        r_next.cap_done = 1'b1;
      end
    end
    r_next.pll_eff = r_reg.sw_en ? r_reg.mode : r_reg.pll_cap;
    r_next.out_en  = pdn ? r_reg.oe_bits : 12'h000;
    if (!pdn) begin
      r_next.st     = CBSMB_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (start) begin
      r_next.st       = CBSMB_RX;
      r_next.bitcnt   = 4'h0;
      r_next.wb       = 2'h0;
      r_next.cnt_sent = 1'b0;
      r_next.sda_oe   = 1'b0;
    end else if (stop) begin
      r_next.st     = CBSMB_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.st)
        CBSMB_RX: begin
          if (rise) begin
            r_next.shreg  = {r_reg.shreg[6:0], sda};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (fall && r_reg.bitcnt == 4'h8) begin
            r_next.bitcnt = 4'h0;
            r_next.st     = CBSMB_ACK;
            r_next.sda_oe = 1'b1;
            if (r_reg.wb == 2'h0) begin
              r_next.rw = r_reg.shreg[0];
              if (r_reg.shreg[7:1] != DEV_ADDR) begin
                r_next.st     = CBSMB_SKIP;
                r_next.sda_oe = 1'b0;
              end
            end else if (r_reg.wb == 2'h1) begin
              ev_cmd       = 1'b1;
              r_next.blk   = ~r_reg.shreg[`CBSMB_BIT_CMD_BYTE];
              r_next.idx   = {1'b0, r_reg.shreg[6:0]};
            end else if (r_reg.wb == 2'h3 || !r_reg.blk) begin
              ev_wr      = 1'b1;
              r_next.idx = r_reg.idx + 8'h01;
              case (r_reg.idx)
                `CBSMB_OFS_CTRL: begin
                  r_next.sw_en = r_reg.shreg[`CBSMB_BIT_SWEN];
                  r_next.mode  = r_reg.shreg[`CBSMB_BIT_MODE_HI:
                                             `CBSMB_BIT_MODE_LO];
                end
                `CBSMB_OFS_OE_LO: r_next.oe_bits[7:0] = r_reg.shreg;
                `CBSMB_OFS_OE_HI: r_next.oe_bits[11:8] = r_reg.shreg[3:0];
                `CBSMB_OFS_BCNT:  r_next.bcnt = r_reg.shreg[4:0];
                default: ;
              endcase
            end
            if (r_reg.wb != 2'h3) begin
              r_next.wb = r_reg.wb + 2'h1;
            end
          end
        end
        CBSMB_ACK: begin
          if (fall) begin
            r_next.sda_oe = 1'b0;
            if (r_reg.rw) begin
              load = 1'b1;
            end else begin
              r_next.st = CBSMB_RX;
            end
          end
        end
        CBSMB_TX: begin
          if (fall) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
            r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.shreg[6];
            if (r_reg.bitcnt == 4'h7) begin
              r_next.st     = CBSMB_RACK;
              r_next.sda_oe = 1'b0;
            end
          end
        end
        CBSMB_RACK: begin
          if (rise) begin
            r_next.hacked = ~sda;
          end
          if (fall) begin
            if (r_reg.hacked) begin
              load = 1'b1;
            end else begin
              r_next.st = CBSMB_SKIP;
            end
          end
        end
        CBSMB_IDLE, CBSMB_SKIP: ;
        default: r_next.st = CBSMB_IDLE;
      endcase
    end
    if (load) begin
      if (r_reg.blk && !r_reg.cnt_sent) begin
        ev_cnt          = 1'b1;
        r_next.cnt_sent = 1'b1;
        txb = (r_reg.bcnt == 5'h00) ? 8'h01 : {3'h0, r_reg.bcnt};
      end else begin
        txb        = rd_reg(r_reg.idx, r_reg);
        r_next.idx = r_reg.idx + 8'h01;
      end
      r_next.shreg  = txb;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = ~txb[7];
      r_next.st     = CBSMB_TX;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      r_reg         <= '0;
      r_reg.scl_d   <= 1'b1;
      r_reg.sda_d   <= 1'b1;
      r_reg.sw_en   <= `CBSMB_RST_SWEN;
      r_reg.mode    <= `CBSMB_RST_MODE;
      r_reg.oe_bits <= {`CBSMB_RST_OE_HI, `CBSMB_RST_OE_LO};
      r_reg.bcnt    <= `CBSMB_RST_BCNT;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sda                      = 1'b0;
  assign o_sda_oe                   = r_reg.sda_oe;
  assign o_differential_clock_out_en = r_reg.out_en;
  assign o_pll_mode                 = r_reg.pll_eff;
  assign o_output_frequency_sel     = r_reg.freq_cap;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_cmd_kind: assert property (ev_cmd |=>
    r_reg.blk == ~$past(r_reg.shreg[7]))
    else $error("command bit 7 did not set the transfer type");
  chk_cmd_index: assert property (ev_cmd |=>
    r_reg.idx == {1'b0, $past(r_reg.shreg[6:0])})
    else $error("command byte did not load the index");
  chk_index_step: assert property (ev_wr |=>
    r_reg.idx == $past(r_reg.idx) + 8'h01)
    else $error("index did not advance after a data byte");
  chk_write_ack: assert property ((ev_wr || ev_cmd) |=>
    r_reg.sda_oe && r_reg.st == CBSMB_ACK)
    else $error("received byte was not acknowledged");
  chk_count_range: assert property (ev_cnt |=>
    r_reg.shreg != 8'h00 && r_reg.shreg <= {2'h0, `CBSMB_MAX_COUNT})
    else $error("block read count out of range");
  chk_pll_select: assert property (r_reg.cap_done |=>
    o_pll_mode == ($past(r_reg.sw_en) ? $past(r_reg.mode)
                                      : $past(r_reg.pll_cap)))
    else $error("PLL mode source is wrong");
  chk_strap_hold: assert property (r_reg.cap_done |=>
    $stable(r_reg.pll_cap) && $stable(r_reg.freq_cap))
    else $error("captured strap changed");
  chk_out_gate: assert property (!pdn |=>
    o_differential_clock_out_en == 12'h000)
    else $error("outputs not held low in power down");
  chk_pd_float: assert property (!pdn ##1 !pdn |->
    !o_sda_oe && $stable(r_reg.oe_bits))
    else $error("bus driven or registers lost in power down");
  chk_reserved_zero: assert property (load && !ev_cnt &&
    r_reg.idx inside {`CBSMB_OFS_CTRL, `CBSMB_OFS_RSV_A, `CBSMB_OFS_RSV_B}
    |=> r_reg.shreg[5:4] == 2'h0 &&
    ($past(r_reg.idx) == `CBSMB_OFS_CTRL || r_reg.shreg == 8'h00))
    else $error("reserved bits read nonzero");

  cov_block_write: cover property (ev_wr && r_reg.blk);
  cov_byte_read: cover property (load && !r_reg.blk);
  cov_block_read: cover property (ev_cnt ##[1:1000] load);
endmodule // cbsmb_target
`default_nettype wire

// >>> design/placeholder_none.sv
// Intentionally empty companion; no logic.
`default_nettype none
`default_nettype wire

// >>> bench/cbsmb_host.sv
// Behavioural SMBus host that drives the clock buffer target.
// Assumes an external pull-up on SDA and a 125 ns SCL period.
`default_nettype none
module cbsmb_host (
  // Bus pins
  output var  logic o_scl,
  output var  logic o_sda_oe,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] rx_data;
  event       rx_done;

  ////////////////////////////////////////////////////////////////////////
  // SCL stands high and SDA released outside frames
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // One bit: set SDA while SCL low, sample in the middle of SCL high
  task automatic bit_io(input logic b, output logic s);
    #31 o_sda_oe = ~b;
    #31 o_scl = 1'b1;
    #31 s = i_sda;
    #32 o_scl = 1'b0;
  endtask

  // Start or repeated start
  task automatic start();
    #31 o_sda_oe = 1'b0;
    #31 o_scl = 1'b1;
    #31 o_sda_oe = 1'b1;
    #32 o_scl = 1'b0;
  endtask

  task automatic stop();
    #31 o_sda_oe = 1'b1;
    #31 o_scl = 1'b1;
    #31 o_sda_oe = 1'b0;
    #32;
  endtask

  // Byte out, MSB first, then sample the target's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Byte in; the last byte is answered with a NAK
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
    rx_data = d;
    ->rx_done;
  endtask
endmodule // cbsmb_host
`default_nettype wire

// >>> bench/smbus_clock_buffer_ctrl_regs_test.sv
// Self-checking bench of the clock buffer SMBus target and registers.
// Assumes the design files and cbsmb_defs.svh are compiled first.
`default_nettype none
`include "cbsmb_defs.svh"
module smbus_clock_buffer_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_mclk;
  logic        i_rst;
  logic        scl;
  logic        host_oe;
  logic        sda_w;
  logic        o_sda;
  logic        o_sda_oe;
  logic        freq_s;
  logic [1:0]  pll_s;
  logic        pdn;
  logic [11:0] out_en;
  logic [1:0]  pll_mode;
  logic        freq_sel;
  logic [7:0]  exp_q[$];
  logic [7:0]  a_v;
  logic [7:0]  b_v;
  logic        ack;
  logic [1:0]  codes[3] = '{2'h0, 2'h1, 2'h3};
  int          seed;
  int          bad_count;
  int          comparisons;

  // Open-drain SDA with pull-up
  assign sda_w = ~((o_sda_oe & ~o_sda) | host_oe);

  cbsmb_target i_dut (
    .i_mclk                     (i_mclk),
    .i_rst                      (i_rst),
    .i_scl                      (scl),
    .i_sda                      (sda_w),
    .o_sda                      (o_sda),
    .o_sda_oe                   (o_sda_oe),
    .i_output_frequency_strap   (freq_s),
    .i_pll_bandwidth_strap      (pll_s),
    .i_power_down_n             (pdn),
    .o_differential_clock_out_en(out_en),
    .o_pll_mode                 (pll_mode),
    .o_output_frequency_sel     (freq_sel)
  );

  cbsmb_host i_host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda_w));

  always #5 i_mclk = ~i_mclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: port %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] b);
    logic a;
    i_host.wbyte(b, a);
    cmp_val({11'h000, a}, 12'h001);
  endtask

  task automatic addr(input logic rd);
    i_host.start();
    wr({`CBSMB_DEV_ADDR, rd});
  endtask

  task automatic xfer_wr(input logic [7:0] cmd, input logic [7:0] d[$]);
    addr(1'b0);
    wr(cmd);
    if (!cmd[7]) wr(8'(d.size()));
    foreach (d[k]) wr(d[k]);
    i_host.stop();
  endtask

  task automatic xfer_rd(input logic [7:0] cmd, input int n);
    logic [7:0] v;
    addr(1'b0);
    wr(cmd);
    addr(1'b1);
    for (int k = 0; k < n; k++) i_host.rbyte(k == n - 1, v);
    i_host.stop();
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  function automatic logic [7:0] reg0(input logic sw, input logic [1:0] m);
    return {pll_s, 2'h0, sw, m, freq_s};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Result watcher: oldest note against each byte read
  initial forever begin
    @(i_host.rx_done);
    cmp_byte(i_host.rx_data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  end

  initial begin
    #500us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    seed = 81;
    i_mclk = 1'b0;
    i_rst = 1'b1;
    pdn = 1'b1;
    freq_s = 1'($random(seed));
    pll_s = codes[{$random(seed)} % 3];
    wait_clk(2);
    i_rst = 1'b0;
    wait_clk(20);
    cmp_val(out_en, 12'hFFF);
    cmp_val({10'h000, pll_mode}, {10'h000, pll_s});
    cmp_val({11'h000, freq_sel}, {11'h000, freq_s});
    $display("test defaults done");
    exp_q = '{8'h08, reg0(1'b0, 2'h3), 8'hFF, 8'h0F, 8'h00, 8'h00};
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h08);
    xfer_rd(8'h00, 9);
    $display("test block read done");
    foreach (codes[c]) begin
      xfer_wr(8'h80, '{{5'h1F, codes[c], 1'b1}});
      wait_clk(4);
      cmp_val({10'h000, pll_mode}, {10'h000, codes[c]});
      exp_q.push_back(reg0(1'b1, codes[c]));
      xfer_rd(8'h80, 1);
    end
    $display("test override done");
    wait_clk(1);
    freq_s = 1'($random(seed));
    pll_s = codes[{$random(seed)} % 3];
    i_rst = 1'b1;
    wait_clk(2);
    i_rst = 1'b0;
    wait_clk(20);
    cmp_val({10'h000, pll_mode}, {10'h000, pll_s});
    cmp_val({11'h000, freq_sel}, {11'h000, freq_s});
    exp_q = '{reg0(1'b0, 2'h3), 8'hFF};
    xfer_rd(8'h80, 2);
    $display("test warm reset done");
    a_v = 8'($random(seed));
    b_v = 8'($random(seed));
    xfer_wr(8'h00, '{8'h06, a_v, b_v});
    wait_clk(4);
    cmp_val(out_en, {b_v[3:0], a_v});
    cmp_val({10'h000, pll_mode}, {10'h000, pll_s});
    exp_q = '{8'h08, a_v, {4'h0, b_v[3:0]}, 8'h00, 8'h00, 8'h00};
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h08);
    exp_q.push_back(8'h00);
    xfer_rd(8'h01, 9);
    $display("test block write done");
    xfer_wr(8'h83, '{8'hFF});
    exp_q.push_back(8'h00);
    xfer_rd(8'h83, 1);
    xfer_wr(8'h87, '{8'h02});
    exp_q = '{8'h02, 8'h00, 8'h00};
    xfer_rd(8'h03, 3);
    xfer_wr(8'h87, '{8'h00});
    exp_q = '{8'h01, 8'h00};
    xfer_rd(8'h04, 2);
    $display("test reserved and count done");
    i_host.start();
    i_host.wbyte({`CBSMB_DEV_ADDR ^ 7'h01, 1'b0}, ack);
    cmp_val({11'h000, ack}, 12'h000);
    i_host.stop();
    $display("test wrong address done");
    wait_clk(1);
    pdn = 1'b0;
    wait_clk(10);
    cmp_val(out_en, 12'h000);
    i_host.start();
    i_host.wbyte({`CBSMB_DEV_ADDR, 1'b0}, ack);
    cmp_val({11'h000, ack}, 12'h000);
    i_host.stop();
    wait_clk(1);
    pdn = 1'b1;
    wait_clk(10);
    cmp_val(out_en, {b_v[3:0], a_v});
    $display("test power down done");
    tally_and_finish();
  end
endmodule // smbus_clock_buffer_ctrl_regs_test
`default_nettype wire
